/* File: include/dcp_map.svh */
// Register map, field positions, reset values and sizes of the DMA channel control block
//
// How it works
// - Control word bit 30 drives HPROT[3]; 1 cacheable, 0 not; resets 0.
// - Setup bits 0-4, 6-9, 11-16 and 18 are read/write; writes cannot change bit 17 or any other bit.
// - Fetching a new linked-list item never alters the setup registers.
// - Writing 1 to setup bit 0 enables the channel.
// - Clearing enable lets the running transfer finish, then disables and flushes FIFO.
// - Hardware clears enable after the last list item or on channel error.
// - While halt is set, peripheral requests are ignored; FIFO keeps draining.
// - Each enable bit also shows in the enabled channels summary register.
// - Enable bit reads 0 when disabled, 1 when enabled; 0 after reset.
// - Setup bit 17 reads 1 while the channel FIFO holds data, else 0.
// - Control bit 28 drives HPROT[1], bit 29 drives HPROT[2]; both reset 0.
`ifndef DCP_MAP_SVH
`define DCP_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define DCP_INT_STAT_ADDR 32'hffe04000
`define DCP_INT_EN_ADDR 32'hffe04004
`define DCP_INT_CLR_ADDR 32'hffe04008
`define DCP_ENABLED_ADDR 32'hffe0401c
`define DCP_CH0_CTRL_ADDR 32'hffe0410c
`define DCP_CH0_SETUP_ADDR 32'hffe04110
`define DCP_CH1_CTRL_ADDR 32'hffe0412c
`define DCP_CH1_SETUP_ADDR 32'hffe04130

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DCP_SET_ENABLE 0
`define DCP_SET_ACTIVE 17
`define DCP_SET_HALT 18
`define DCP_CTRL_PRIV 28
`define DCP_CTRL_BUFF 29
`define DCP_CTRL_CACHE 30
`define DCP_INT_TC_LSB 0
`define DCP_INT_ERR_LSB 2

// ----------------------------------------
// Masks, reset values and sizes
// ----------------------------------------
`define DCP_SET_WMASK 32'h0005fbdf
`define DCP_SETUP_RST 32'h00000000
`define DCP_CTRL_RST 32'h00000000
`define DCP_INT_RST 4'h0
`define DCP_FIFO_DEPTH 4
`define DCP_CHANNELS 2

`endif

/* File: include/dcp_pkg.sv */
// Types shared by the DMA channel control block
package dcp_pkg;
	typedef logic [31:0] dcp_word_t;
	// Gray order along idle -> read -> write
	typedef enum logic [1:0] {
		DCP_IDLE = 2'b00,
		DCP_READ = 2'b01,
		DCP_WRITE = 2'b11
	} dcp_state_e;
endpackage

/* File: tb/dcp_ahb_model.sv */
// Transfer-side responder model for the DMA channel control block
`timescale 1ns/100ps
`default_nettype none
module dcp_ahb_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Transfer lanes
	input wire logic [1:0] xfer_req,
	output logic [1:0] xfer_done,
	// Latency select
	input wire logic slow
);
	// ----------------------------------------
	// Responder
	// ----------------------------------------
	logic [3:0] wait_cnt [2];
	// One done pulse per request, after 1 or 8 cycles
	always_ff @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (rst || !xfer_req[i] || xfer_done[i]) begin
				wait_cnt[i] <= 4'h0;
				xfer_done[i] <= 1'b0;
			end else begin
				wait_cnt[i] <= wait_cnt[i] + 4'h1;
				xfer_done[i] <= (wait_cnt[i] == (slow ? 4'h7 : 4'h0));
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the DMA channel control block
`timescale 1ns/100ps
`default_nettype none
`include "dcp_map.svh"
module tb_top;
	import dcp_pkg::*;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic CLOCK, RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IRQ, slow;
	logic [31:0] AVS_ADDRESS;
	dcp_word_t AVS_WRITEDATA, AVS_READDATA, rd;
	logic [3:0] AVS_BYTEENABLE, HPROT0, HPROT1;
	logic [1:0] DMA_REQ, LLI_LAST, CH_ERROR, XFER_REQ, XFER_WRITE, XFER_DONE;
	int mismatches, samples_checked, hits;
	dcp_top dcp_top_inst (.CLOCK(CLOCK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .DMA_REQ(DMA_REQ), .LLI_LAST(LLI_LAST),
		.CH_ERROR(CH_ERROR), .XFER_REQ(XFER_REQ), .XFER_WRITE(XFER_WRITE),
		.XFER_DONE(XFER_DONE), .HPROT0(HPROT0), .HPROT1(HPROT1), .IRQ(IRQ));
	dcp_ahb_model dcp_ahb_model_inst (.clk(CLOCK), .rst(RST), .xfer_req(XFER_REQ),
		.xfer_done(XFER_DONE), .slow(slow));
	// 100 MHz clock
	initial begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end
	// Verdict and end of run
	task automatic stop_test();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [31:0] addr, input dcp_word_t data);
		int n;
		n = 0;
		@(posedge CLOCK);
		AVS_ADDRESS <= addr;
		AVS_WRITEDATA <= data;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		do begin
			@(posedge CLOCK);
			n++;
			if (n > 50) begin
				mismatches++;
				stop_test();
			end
		end while (AVS_WAITREQUEST !== 1'b0);
		rd = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, input dcp_word_t d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [31:0] a, input dcp_word_t e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic irq_is(input logic e);
		@(posedge CLOCK);
		chk(32'(IRQ), 32'(e));
	endtask
	// Bounded wait for a lane request level
	task automatic wait_req(input int ch, input logic v);
		int n;
		n = 0;
		while (XFER_REQ[ch] !== v) begin
			@(posedge CLOCK);
			n++;
			if (n > 100) begin
				mismatches++;
				stop_test();
			end
		end
	endtask
	task automatic count_req(input int ch, output int h);
		h = 0;
		repeat (20) begin
			@(posedge CLOCK);
			if (XFER_REQ[ch] !== 1'b0) h++;
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// reset values
	task automatic t_reset();
		rdc(`DCP_CH0_SETUP_ADDR, 32'h0);
		rdc(`DCP_CH1_SETUP_ADDR, 32'h0);
		rdc(`DCP_ENABLED_ADDR, 32'h0);
		chk(32'(HPROT0), 32'h1);
	endtask
	task automatic t_access();
		wr(`DCP_CH1_SETUP_ADDR, 32'hffffffff);
		rdc(`DCP_CH1_SETUP_ADDR, `DCP_SET_WMASK);
		rdc(`DCP_ENABLED_ADDR, 32'h2);
		rdc(32'hffe04ff0, 32'h0);
		@(posedge CLOCK);
		CH_ERROR <= 2'b10;
		@(posedge CLOCK);
		CH_ERROR <= 2'b00;
		rdc(`DCP_CH1_SETUP_ADDR, `DCP_SET_WMASK & ~32'h1);
		rdc(`DCP_ENABLED_ADDR, 32'h0);
		rdc(`DCP_INT_STAT_ADDR, 32'h8);
		irq_is(1'b0);
		wr(`DCP_INT_EN_ADDR, 32'hf);
		irq_is(1'b1);
		wr(`DCP_INT_CLR_ADDR, 32'h8);
		irq_is(1'b0);
	endtask
	task automatic t_prot();
		wr(`DCP_CH0_CTRL_ADDR, 32'h50000000);
		wr(`DCP_CH0_SETUP_ADDR, 32'h1);
		DMA_REQ <= 2'b01;
		wait_req(0, 1'b1);
		DMA_REQ <= 2'b00;
		chk(32'(HPROT0), 32'hb);
		chk(32'(XFER_WRITE[0]), 32'h0);
		wr(`DCP_CH0_CTRL_ADDR, 32'h0);
		chk(32'(HPROT0), 32'hb);
		wait_req(0, 1'b0);
		wait_req(0, 1'b1);
		chk(32'(XFER_WRITE[0]), 32'h1);
		chk(32'(HPROT0), 32'h1);
		rdc(`DCP_CH0_SETUP_ADDR, 32'h20001);
		wait_req(0, 1'b0);
		rdc(`DCP_CH0_SETUP_ADDR, 32'h1);
	endtask
	task automatic t_halt();
		wr(`DCP_CH0_CTRL_ADDR, 32'h20000000);
		DMA_REQ <= 2'b01;
		wait_req(0, 1'b1);
		chk(32'(HPROT0), 32'h5);
		wr(`DCP_CH0_SETUP_ADDR, 32'h40001);
		wait_req(0, 1'b0);
		wait_req(0, 1'b1);
		chk(32'(XFER_WRITE[0]), 32'h1);
		for (int i = 0; i < 20; i++) begin
			bus(1'b0, `DCP_CH0_SETUP_ADDR, 32'h0);
			if (rd[17] === 1'b0) break;
		end
		chk(rd, 32'h40001);
		count_req(0, hits);
		chk(hits, 0);
		wr(`DCP_CH0_SETUP_ADDR, 32'h40000);
		DMA_REQ <= 2'b00;
		rdc(`DCP_ENABLED_ADDR, 32'h0);
	endtask
	task automatic t_abort();
		wr(`DCP_CH0_CTRL_ADDR, 32'h0);
		wr(`DCP_CH0_SETUP_ADDR, 32'h1);
		DMA_REQ <= 2'b01;
		wait_req(0, 1'b1);
		DMA_REQ <= 2'b00;
		wr(`DCP_CH0_SETUP_ADDR, 32'h0);
		chk(32'(XFER_REQ[0]), 32'h1);
		wait_req(0, 1'b0);
		count_req(0, hits);
		chk(hits, 0);
		rdc(`DCP_CH0_SETUP_ADDR, 32'h0);
	endtask
	task automatic t_last();
		slow <= 1'b0;
		wr(`DCP_CH0_SETUP_ADDR, 32'h1);
		DMA_REQ <= 2'b01;
		wait_req(0, 1'b1);
		DMA_REQ <= 2'b00;
		@(posedge CLOCK);
		LLI_LAST <= 2'b01;
		@(posedge CLOCK);
		LLI_LAST <= 2'b00;
		rdc(`DCP_ENABLED_ADDR, 32'h0);
		rdc(`DCP_INT_STAT_ADDR, 32'h1);
		irq_is(1'b1);
		wr(`DCP_INT_CLR_ADDR, 32'h1);
		irq_is(1'b0);
	endtask
	task automatic t_chan1();
		slow <= 1'b1;
		wr(`DCP_CH1_CTRL_ADDR, 32'h70000000);
		wr(`DCP_CH1_SETUP_ADDR, 32'h1);
		DMA_REQ <= 2'b10;
		wait_req(1, 1'b1);
		DMA_REQ <= 2'b00;
		chk(32'(HPROT1), 32'hf);
		chk(32'(XFER_WRITE[1]), 32'h0);
		wait_req(1, 1'b0);
		rdc(`DCP_CH1_SETUP_ADDR, 32'h20001);
		chk(32'(XFER_WRITE[1]), 32'h1);
		@(posedge CLOCK);
		CH_ERROR <= 2'b11;
		@(posedge CLOCK);
		CH_ERROR <= 2'b00;
		rdc(`DCP_ENABLED_ADDR, 32'h0);
		rdc(`DCP_INT_STAT_ADDR, 32'hc);
		wr(`DCP_INT_CLR_ADDR, 32'hc);
		irq_is(1'b0);
		wait_req(1, 1'b0);
		chk(32'(HPROT1), 32'hf);
		rdc(`DCP_CH1_SETUP_ADDR, 32'h0);
	endtask
	// Main sequence
	initial begin
		RST = 1'b1;
		AVS_ADDRESS = 32'h0;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_WRITEDATA = 32'h0;
		AVS_BYTEENABLE = 4'hf;
		DMA_REQ = 2'b00;
		LLI_LAST = 2'b00;
		CH_ERROR = 2'b00;
		slow = 1'b1;
		mismatches = 0;
		samples_checked = 0;
		repeat (20) @(posedge CLOCK);
		RST <= 1'b0;
		t_reset();
		t_access();
		t_prot();
		t_halt();
		t_abort();
		t_last();
		t_chan1();
		stop_test();
	end
endmodule
`default_nettype wire

/* File: verilog/dcp_chan.sv */
// One DMA channel engine: transfer sequencing, FIFO fill level and protection qualifiers
`timescale 1ns/100ps
`default_nettype none
`include "dcp_map.svh"
module dcp_chan #(
	parameter int DEPTH = `DCP_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Channel controls
	input wire logic en,
	input wire logic halt,
	input wire logic [2:0] prot,
	// Peripheral request, already synchronised
	input wire logic req,
	// Transfer side
	output logic xfer_req,
	output logic xfer_write,
	input wire logic xfer_done,
	output logic [3:0] hprot,
	// Status
	output logic active
);
	import dcp_pkg::*;

	localparam int CW = $clog2(DEPTH + 1);
	dcp_state_e state;
	logic [CW-1:0] count;
	logic [3:0] hprot_q;

	// ----------------------------------------
	// Transfer sequencing
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= DCP_IDLE;
			hprot_q <= 4'h1;
		end else begin
			case (state)
				DCP_IDLE: begin
					if (en && !halt && req && count < CW'(DEPTH)) begin
						state <= DCP_READ;
						hprot_q <= {prot, 1'b1};
					end else if (en && count != '0) begin
						state <= DCP_WRITE;
						hprot_q <= {prot, 1'b1};
					end
				end
				DCP_READ, DCP_WRITE: begin
					if (xfer_done) begin
						state <= DCP_IDLE;
					end
				end
				default: begin
					state <= DCP_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// FIFO fill level
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			count <= '0;
		end else if (!en && state == DCP_IDLE) begin
			count <= '0;
		end else if (state == DCP_READ && xfer_done) begin
			count <= count + CW'(1);
		end else if (state == DCP_WRITE && xfer_done) begin
			count <= count - CW'(1);
		end
	end

	// Outputs; qualifiers latched at address phase
	assign xfer_req = (state != DCP_IDLE);
	assign xfer_write = (state == DCP_WRITE);
	assign hprot = hprot_q;
	assign active = (count != '0);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_hprot_hold;
		xfer_req && !xfer_done |=> $stable(hprot);
	endproperty
	a_hprot_hold: assert property (p_hprot_hold) else $error("hprot moved mid transfer");

	property p_cache_bit;
		$rose(xfer_req) |-> hprot[3] == $past(prot[2]);
	endproperty
	a_cache_bit: assert property (p_cache_bit) else $error("hprot3 not from cache bit");

	property p_priv_buff;
		$rose(xfer_req) |-> hprot[2:1] == $past(prot[1:0]);
	endproperty
	a_priv_buff: assert property (p_priv_buff) else $error("hprot2/1 wrong");

	property p_halt_ignore;
		halt && state == DCP_IDLE |=> state != DCP_READ;
	endproperty
	a_halt_ignore: assert property (p_halt_ignore) else $error("read while halted");

	sequence s_drain_wait;
		en && halt && active && state == DCP_IDLE;
	endsequence
	property p_halt_drain;
		s_drain_wait |=> state == DCP_WRITE;
	endproperty
	a_halt_drain: assert property (p_halt_drain) else $error("halted FIFO not drained");

	property p_flush;
		!en && state == DCP_IDLE |=> !active;
	endproperty
	a_flush: assert property (p_flush) else $error("FIFO kept after disable");

	property p_finish;
		xfer_req && !xfer_done |=> xfer_req && $stable(xfer_write);
	endproperty
	a_finish: assert property (p_finish) else $error("transfer dropped");

	property p_active_clear;
		xfer_write && xfer_done && count == CW'(1) |=> !active;
	endproperty
	a_active_clear: assert property (p_active_clear) else $error("active stuck");
endmodule
`default_nettype wire

/* File: verilog/dcp_top.sv */
// Two-channel DMA control block: register slave, channel enable control and interrupts
`timescale 1ns/100ps
`default_nettype none
`include "dcp_map.svh"
module dcp_top #(
	parameter int FIFO_DEPTH = `DCP_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// Avalon-MM register slave
	input wire logic [31:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire dcp_pkg::dcp_word_t AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output dcp_pkg::dcp_word_t AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Peripheral requests, one per channel, asynchronous
	input wire logic [1:0] DMA_REQ,
	// Linked-list and error events from the list logic
	input wire logic [1:0] LLI_LAST,
	input wire logic [1:0] CH_ERROR,
	// Transfer side, one lane per channel
	output logic [1:0] XFER_REQ,
	output logic [1:0] XFER_WRITE,
	input wire logic [1:0] XFER_DONE,
	output logic [3:0] HPROT0,
	output logic [3:0] HPROT1,
	// Interrupt
	output logic IRQ
);
	import dcp_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	dcp_word_t setup_q [2];
	dcp_word_t ctrl_q [2];
	logic [3:0] int_stat;
	logic [3:0] int_en;
	logic [1:0] req_s1;
	logic [1:0] req_s2;
	logic [1:0] active;
	logic [1:0] enabled;
	logic [3:0] hprot_ch [2];
	logic ack;
	logic wr_hit;
	logic [3:0] int_set;
	logic [3:0] int_clr;

	// Merge byte lanes of a write into an old value
	function automatic dcp_word_t merge(input dcp_word_t old, input dcp_word_t data,
		input logic [3:0] be);
		dcp_word_t res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Setup register as software sees it
	function automatic dcp_word_t setup_view(input dcp_word_t stored, input logic act);
		dcp_word_t res;
		res = stored & `DCP_SET_WMASK;
		res[`DCP_SET_ACTIVE] = act;
		return res;
	endfunction

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	// One wait cycle per access; write lands when waitrequest is low
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ack <= 1'b0;
		end else begin
			ack <= (AVS_READ || AVS_WRITE) && !ack;
		end
	end

	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;
	assign wr_hit = AVS_WRITE && ack;

	// ----------------------------------------
	// Peripheral request synchroniser
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			req_s1 <= 2'b00;
			req_s2 <= 2'b00;
		end else begin
			req_s1 <= DMA_REQ;
			req_s2 <= req_s1;
		end
	end

	// ----------------------------------------
	// Setup and control registers
	// ----------------------------------------
	// software writes change setup; end or error events clear enable
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			setup_q[0] <= `DCP_SETUP_RST;
			setup_q[1] <= `DCP_SETUP_RST;
		end else begin
			for (int c = 0; c < 2; c++) begin
				dcp_word_t nv;
				nv = setup_q[c];
				if (wr_hit && AVS_ADDRESS == (c == 0 ? `DCP_CH0_SETUP_ADDR : `DCP_CH1_SETUP_ADDR)) begin
					nv = merge(setup_q[c], AVS_WRITEDATA, AVS_BYTEENABLE) & `DCP_SET_WMASK;
				end
				// auto clear on end or error
				if (LLI_LAST[c] || CH_ERROR[c]) begin
					nv[`DCP_SET_ENABLE] = 1'b0;
				end
				setup_q[c] <= nv;
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ctrl_q[0] <= `DCP_CTRL_RST;
			ctrl_q[1] <= `DCP_CTRL_RST;
		end else if (wr_hit) begin
			if (AVS_ADDRESS == `DCP_CH0_CTRL_ADDR) begin
				ctrl_q[0] <= merge(ctrl_q[0], AVS_WRITEDATA, AVS_BYTEENABLE);
			end
			if (AVS_ADDRESS == `DCP_CH1_CTRL_ADDR) begin
				ctrl_q[1] <= merge(ctrl_q[1], AVS_WRITEDATA, AVS_BYTEENABLE);
			end
		end
	end

	assign enabled = {setup_q[1][`DCP_SET_ENABLE], setup_q[0][`DCP_SET_ENABLE]};

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	// Events and software clears for the sticky status
	assign int_set = {CH_ERROR, LLI_LAST};
	assign int_clr = (wr_hit && AVS_ADDRESS == `DCP_INT_CLR_ADDR) ? AVS_WRITEDATA[3:0] : 4'h0;

	// Set wins over a clear in the same cycle
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			int_stat <= `DCP_INT_RST;
		end else begin
			int_stat <= (int_stat & ~int_clr) | int_set;
		end
	end

	// Interrupt enable register
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			int_en <= `DCP_INT_RST;
		end else if (wr_hit && AVS_ADDRESS == `DCP_INT_EN_ADDR && AVS_BYTEENABLE[0]) begin
			int_en <= AVS_WRITEDATA[3:0];
		end
	end

	assign IRQ = |(int_stat & int_en);

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Captured in the wait cycle, stands when waitrequest drops
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			AVS_READDATA <= '0;
		end else if (AVS_READ && !ack) begin
			case (AVS_ADDRESS)
				`DCP_CH0_SETUP_ADDR: AVS_READDATA <= setup_view(setup_q[0], active[0]);
				`DCP_CH1_SETUP_ADDR: AVS_READDATA <= setup_view(setup_q[1], active[1]);
				`DCP_CH0_CTRL_ADDR: AVS_READDATA <= ctrl_q[0];
				`DCP_CH1_CTRL_ADDR: AVS_READDATA <= ctrl_q[1];
				`DCP_ENABLED_ADDR: AVS_READDATA <= {30'h0, enabled};
				`DCP_INT_STAT_ADDR: AVS_READDATA <= {28'h0, int_stat};
				`DCP_INT_EN_ADDR: AVS_READDATA <= {28'h0, int_en};
				default: AVS_READDATA <= '0;
			endcase
		end
	end

	// ----------------------------------------
	// Channel engines
	// ----------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_chan
		dcp_chan #(
			.DEPTH(FIFO_DEPTH)
		) u_chan (
			.clk(CLOCK),
			.rst(RST),
			.en(setup_q[g][`DCP_SET_ENABLE]),
			.halt(setup_q[g][`DCP_SET_HALT]),
			.prot(ctrl_q[g][`DCP_CTRL_CACHE:`DCP_CTRL_PRIV]),
			.req(req_s2[g]),
			.xfer_req(XFER_REQ[g]),
			.xfer_write(XFER_WRITE[g]),
			.xfer_done(XFER_DONE[g]),
			.hprot(hprot_ch[g]),
			.active(active[g])
		);
	end

	assign HPROT0 = hprot_ch[0];
	assign HPROT1 = hprot_ch[1];

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	sequence s_setup0_write;
		wr_hit && AVS_ADDRESS == `DCP_CH0_SETUP_ADDR && AVS_BYTEENABLE[0];
	endsequence

	property p_enable_write;
		s_setup0_write ##0 (AVS_WRITEDATA[0] && !LLI_LAST[0] && !CH_ERROR[0])
			|=> setup_q[0][`DCP_SET_ENABLE];
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable not set");

	property p_auto_clear;
		LLI_LAST[1] || CH_ERROR[1] |=> !enabled[1];
	endproperty
	a_auto_clear: assert property (p_auto_clear) else $error("enable not auto cleared");

	property p_summary;
		AVS_READ && !ack && AVS_ADDRESS == `DCP_ENABLED_ADDR
			|=> AVS_READDATA[1:0] == $past(enabled) && !AVS_WAITREQUEST;
	endproperty
	a_summary: assert property (p_summary) else $error("summary mismatch");

	property p_active_read;
		AVS_READ && !ack && AVS_ADDRESS == `DCP_CH1_SETUP_ADDR
			|=> AVS_READDATA[`DCP_SET_ACTIVE] == $past(active[1]);
	endproperty
	a_active_read: assert property (p_active_read) else $error("bit 17 not FIFO state");

	property p_ro_bit;
		wr_hit |=> setup_q[0][`DCP_SET_ACTIVE] == 1'b0 && setup_q[1][`DCP_SET_ACTIVE] == 1'b0;
	endproperty
	a_ro_bit: assert property (p_ro_bit) else $error("bit 17 stored");

	property p_setup_stable;
		!wr_hit && !LLI_LAST[0] && !CH_ERROR[0] |=> $stable(setup_q[0]);
	endproperty
	a_setup_stable: assert property (p_setup_stable) else $error("setup changed by hardware");

	property p_reset_off;
		$past(RST) |-> enabled == 2'b00;
	endproperty
	a_reset_off: assert property (p_reset_off) else $error("enable set after reset");

	property p_int_sticky;
		CH_ERROR[0] |=> int_stat[`DCP_INT_ERR_LSB];
	endproperty
	a_int_sticky: assert property (p_int_sticky) else $error("error event lost");

	sequence s_setup1_write;
		wr_hit && AVS_ADDRESS == `DCP_CH1_SETUP_ADDR && AVS_BYTEENABLE[0];
	endsequence

	property p_enable_write1;
		s_setup1_write ##0 (AVS_WRITEDATA[0] && !LLI_LAST[1] && !CH_ERROR[1])
			|=> setup_q[1][`DCP_SET_ENABLE];
	endproperty
	a_enable_write1: assert property (p_enable_write1) else $error("enable 1 not set");

	property p_disable_write;
		s_setup0_write ##0 !AVS_WRITEDATA[0] |=> !enabled[0];
	endproperty
	a_disable_write: assert property (p_disable_write) else $error("enable not cleared");

	property p_auto_clear0;
		LLI_LAST[0] || CH_ERROR[0] |=> !enabled[0];
	endproperty
	a_auto_clear0: assert property (p_auto_clear0) else $error("enable 0 not auto cleared");

	property p_setup1_stable;
		!wr_hit && !LLI_LAST[1] && !CH_ERROR[1] |=> $stable(setup_q[1]);
	endproperty
	a_setup1_stable: assert property (p_setup1_stable) else $error("setup 1 changed");

	property p_enable_read;
		AVS_READ && !ack && AVS_ADDRESS == `DCP_CH0_SETUP_ADDR
			|=> AVS_READDATA[`DCP_SET_ENABLE] == $past(enabled[0]);
	endproperty
	a_enable_read: assert property (p_enable_read) else $error("enable read wrong");

	property p_active_read0;
		AVS_READ && !ack && AVS_ADDRESS == `DCP_CH0_SETUP_ADDR
			|=> AVS_READDATA[`DCP_SET_ACTIVE] == $past(active[0]);
	endproperty
	a_active_read0: assert property (p_active_read0) else $error("bit 17 of ch0 wrong");

	property p_ctrl_write;
		wr_hit && AVS_ADDRESS == `DCP_CH0_CTRL_ADDR && AVS_BYTEENABLE[3]
			|=> ctrl_q[0][`DCP_CTRL_CACHE] == $past(AVS_WRITEDATA[`DCP_CTRL_CACHE]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("cache bit not stored");

	property p_ctrl1_write;
		wr_hit && AVS_ADDRESS == `DCP_CH1_CTRL_ADDR && AVS_BYTEENABLE[3]
			|=> ctrl_q[1][`DCP_CTRL_BUFF:`DCP_CTRL_PRIV]
				== $past(AVS_WRITEDATA[`DCP_CTRL_BUFF:`DCP_CTRL_PRIV]);
	endproperty
	a_ctrl1_write: assert property (p_ctrl1_write) else $error("prot bits not stored");

	property p_hprot0_cache;
		$rose(XFER_REQ[0]) |-> HPROT0[3] == $past(ctrl_q[0][`DCP_CTRL_CACHE]);
	endproperty
	a_hprot0_cache: assert property (p_hprot0_cache) else $error("lane 0 cache wrong");

	property p_hprot1_cache;
		$rose(XFER_REQ[1]) |-> HPROT1[3] == $past(ctrl_q[1][`DCP_CTRL_CACHE]);
	endproperty
	a_hprot1_cache: assert property (p_hprot1_cache) else $error("lane 1 cache wrong");

	property p_hprot1_priv;
		$rose(XFER_REQ[1]) |-> HPROT1[2:1] == $past(ctrl_q[1][`DCP_CTRL_BUFF:`DCP_CTRL_PRIV]);
	endproperty
	a_hprot1_priv: assert property (p_hprot1_priv) else $error("lane 1 prot wrong");

	property p_last_sticky;
		LLI_LAST[0] |=> int_stat[`DCP_INT_TC_LSB];
	endproperty
	a_last_sticky: assert property (p_last_sticky) else $error("last item event lost");

	property p_int_clear;
		wr_hit && AVS_ADDRESS == `DCP_INT_CLR_ADDR && int_set == 4'h0
			|=> (int_stat & $past(AVS_WRITEDATA[3:0])) == 4'h0;
	endproperty
	a_int_clear: assert property (p_int_clear) else $error("status not cleared");

	property p_wait_one;
		(AVS_READ || AVS_WRITE) && !ack |=> ack;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("access not answered");
endmodule
`default_nettype wire
